// >>> include/flash_pkg.sv
// Constants, commands and timing for the host side of a 512K x 16 parallel flash.
// Assumes a 25 MHz system clock and a flash with internally timed program and erase.
package flash_pkg;
  // ---------------------------------------------------------------
  // Widths and pin bit positions
  // ---------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int LOCK_BIT = 0;
  // ---------------------------------------------------------------
  // Command addresses and codes
  // ---------------------------------------------------------------
  localparam logic [18:0] UNLOCK_A1 = 19'h05555;
  localparam logic [18:0] UNLOCK_A2 = 19'h02aaa;
  localparam logic [7:0] UNLOCK_D1 = 8'haa;
  localparam logic [7:0] UNLOCK_D2 = 8'h55;
  localparam logic [7:0] CMD_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROG = 8'ha0;
  localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
  localparam logic [7:0] CMD_ID_EXIT = 8'hf0;
  localparam logic [7:0] CMD_CHIP = 8'h10;
  localparam logic [7:0] CMD_SECT = 8'h30;
  localparam logic [7:0] CMD_LOCK = 8'h40;
  localparam logic [7:0] UPPER_DONT_CARE = 8'h00;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  // ---------------------------------------------------------------
  // Boot block map for both variants
  // ---------------------------------------------------------------
  localparam logic [18:0] BOOT_LO_LAST = 19'h01fff;
  localparam logic [18:0] BOOT_HI_BASE = 19'h7e000;
  localparam logic [18:0] LOCK_STAT_LO = 19'h00002;
  localparam logic [18:0] LOCK_STAT_HI = 19'h7e002;
  // ---------------------------------------------------------------
  // Sequence lengths and user operations
  // ---------------------------------------------------------------
  localparam logic [2:0] LEN_READ = 3'h1;
  localparam logic [2:0] LEN_PROG = 3'h4;
  localparam logic [2:0] LEN_SIX = 3'h6;
  localparam logic [2:0] LEN_IDLOCK = 3'h5;
  localparam logic [2:0] STEP_LAST_UNLOCK = 3'h2;
  localparam logic [2:0] STEP_ID_READ = 3'h3;
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_PROG = 3'h1,
    OP_CHIP = 3'h2,
    OP_SECT = 3'h3,
    OP_LOCK = 3'h4,
    OP_IDLOCK = 3'h5
  } op_t;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int CLK_MHZ = 25;
  localparam int CLK_KHZ = 25000;
  localparam int T_SETUP_NS = 40;
  localparam int T_WE_LOW_NS = 80;
  localparam int T_ACC_NS = 120;
  localparam int T_RST_LOW_NS = 500;
  localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WE_LOW_CYC = 8'((T_WE_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RST_LOW_CYC = 8'((T_RST_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam int T_PROG_MAX_US = 1000;
  localparam int T_ERASE_MAX_MS = 30000;
  localparam logic [31:0] PROG_TMO_CYC = 32'(T_PROG_MAX_US * CLK_MHZ);
  localparam logic [31:0] ERASE_TMO_CYC = 32'(T_ERASE_MAX_MS * CLK_KHZ);
  // ---------------------------------------------------------------
  // Bus cycle engine states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    B_IDLE = 4'b0001,
    B_SETUP = 4'b0010,
    B_STROBE = 4'b0100,
    B_HOLD = 4'b1000
  } bus_state_t;
  // ---------------------------------------------------------------
  // Command sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_ISSUE = 6'b000010,
    S_WAIT = 6'b000100,
    S_POLL = 6'b001000,
    S_PWAIT = 6'b010000,
    S_RST = 6'b100000
  } host_state_t;
endpackage : flash_pkg

// >>> include/flash_cyc_if.sv
// One bus cycle request and answer between the sequencer and the pin engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface flash_cyc_if;
  logic req;
  logic wr;
  logic [18:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic done;
  modport seq (output req, output wr, output addr, output wdata, input rdata, input done);
  modport eng (input req, input wr, input addr, input wdata, output rdata, output done);
endinterface : flash_cyc_if

// >>> rtl/flash_bus_cycle.sv
// Pin engine: performs one write-strobe-controlled write or one read on the flash pins.
// Assumes a request only arrives while the previous one has answered.
`timescale 1ns/1ns
module flash_bus_cycle (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  flash_cyc_if.eng cyc,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [18:0] addr_o,
  output logic [15:0] dq_o,
  output logic dq_oe_o,
  input wire logic [15:0] dq_i
);
  typedef struct packed {
    flash_pkg::bus_state_t st;
    logic wr;
    logic [7:0] cnt;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [18:0] addr;
    logic [15:0] dq;
    logic dq_oe;
    logic [15:0] rdata;
    logic done;
  } bus_t;

  bus_t cur_ff;
  bus_t nxt_cur;

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.done = 1'b0;
    case (cur_ff.st)
      flash_pkg::B_IDLE: begin
        // Deselected: chip select high keeps the flash in standby
        nxt_cur.ce_n = 1'b1;
        nxt_cur.oe_n = 1'b1;
        nxt_cur.we_n = 1'b1;
        nxt_cur.dq_oe = 1'b0;
        if (cyc.req) begin
          nxt_cur.wr = cyc.wr;
          nxt_cur.addr = cyc.addr;
          nxt_cur.dq = cyc.wdata;
          nxt_cur.ce_n = 1'b0;
          nxt_cur.oe_n = cyc.wr; // Output enable high during writes
          nxt_cur.dq_oe = cyc.wr; // Never drive data while the flash may drive
          nxt_cur.cnt = cyc.wr ? flash_pkg::SETUP_CYC : flash_pkg::ACC_CYC;
          nxt_cur.st = flash_pkg::B_SETUP;
        end
      end
      flash_pkg::B_SETUP: begin
        if (cur_ff.cnt > 8'h01) begin
          nxt_cur.cnt = cur_ff.cnt - 8'h01;
        end else if (cur_ff.wr) begin
          // Address is taken on this falling strobe, chip select already low
          nxt_cur.we_n = 1'b0;
          nxt_cur.cnt = flash_pkg::WE_LOW_CYC;
          nxt_cur.st = flash_pkg::B_STROBE;
        end else begin
          // Read data valid after access time with chip select and output enable low
          nxt_cur.rdata = dq_i;
          nxt_cur.oe_n = 1'b1;
          nxt_cur.ce_n = 1'b1;
          nxt_cur.st = flash_pkg::B_HOLD;
        end
      end
      flash_pkg::B_STROBE: begin
        if (cur_ff.cnt > 8'h01) begin
          nxt_cur.cnt = cur_ff.cnt - 8'h01;
        end else begin
          // Rising strobe latches data; data stays driven one more cycle for hold
          nxt_cur.we_n = 1'b1;
          nxt_cur.st = flash_pkg::B_HOLD;
        end
      end
      flash_pkg::B_HOLD: begin
        nxt_cur.ce_n = 1'b1;
        nxt_cur.dq_oe = 1'b0;
        nxt_cur.done = 1'b1;
        nxt_cur.st = flash_pkg::B_IDLE;
      end
      default: begin
        nxt_cur.st = flash_pkg::B_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cur_ff <= '{st: flash_pkg::B_IDLE, wr: 1'b0, cnt: 8'h00, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                  addr: 19'h00000, dq: 16'h0000, dq_oe: 1'b0, rdata: 16'h0000, done: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign ce_n_o = cur_ff.ce_n;
  assign oe_n_o = cur_ff.oe_n;
  assign we_n_o = cur_ff.we_n;
  assign addr_o = cur_ff.addr;
  assign dq_o = cur_ff.dq;
  assign dq_oe_o = cur_ff.dq_oe;
  assign cyc.rdata = cur_ff.rdata;
  assign cyc.done = cur_ff.done;
endmodule : flash_bus_cycle

// >>> rtl/flash_host_ctrl.sv
// Host controller for a 512K x 16 parallel flash: command sequences, polling, reset.
// Assumes the flash pins are wired directly; data pins resolved outside from dq_oe_o.
`timescale 1ns/1ns
module flash_host_ctrl #(
  parameter logic [31:0] PROG_TMO = flash_pkg::PROG_TMO_CYC,
  parameter logic [31:0] ERASE_TMO = flash_pkg::ERASE_TMO_CYC,
  parameter logic BOOT_TOP = 1'b0
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_op_i,
  input wire logic [18:0] cmd_addr_i,
  input wire logic [15:0] cmd_data_i,
  input wire logic abort_i,
  output logic busy_o,
  output logic done_o,
  output logic err_o,
  output logic [15:0] rdata_o,
  output logic locked_o,
  output logic flash_rst_n_o,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [18:0] addr_o,
  output logic [15:0] dq_o,
  output logic dq_oe_o,
  input wire logic [15:0] dq_i
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    flash_pkg::host_state_t st;
    logic [2:0] op;
    logic [18:0] addr;
    logic [15:0] wdata;
    logic [2:0] step;
    logic [15:0] prev;
    logic have_prev;
    logic [31:0] tmo;
    logic [7:0] rcnt;
    logic busy;
    logic done;
    logic err;
    logic [15:0] rdata;
    logic locked;
    logic rst_n;
    logic req;
    logic wr;
    logic [18:0] caddr;
    logic [15:0] cdata;
  } host_t;

  host_t cur_ff;
  host_t nxt_cur;
  flash_cyc_if cyc_bus ();

  // ---------------------------------------------------------------
  // Sequence table: {write, address, data} for each step
  // ---------------------------------------------------------------
  function automatic logic [35:0] seq_word(input logic [2:0] op, input logic [2:0] step,
                                           input logic [18:0] a, input logic [15:0] d);
    logic [7:0] code;
    code = flash_pkg::CMD_SETUP;
    case (op)
      flash_pkg::OP_PROG: code = flash_pkg::CMD_PROG;
      flash_pkg::OP_IDLOCK: code = flash_pkg::CMD_ID_ENTRY;
      default: code = flash_pkg::CMD_SETUP;
    endcase
    seq_word = {1'b1, flash_pkg::UNLOCK_A1, flash_pkg::UPPER_DONT_CARE, flash_pkg::UNLOCK_D1};
    if (op == flash_pkg::OP_READ) begin
      seq_word = {1'b0, a, 16'h0000};
    end else if (step == 3'h1 || (step == 3'h4 && op != flash_pkg::OP_IDLOCK)) begin
      seq_word = {1'b1, flash_pkg::UNLOCK_A2, flash_pkg::UPPER_DONT_CARE, flash_pkg::UNLOCK_D2};
    end else if (step == flash_pkg::STEP_LAST_UNLOCK) begin
      seq_word = {1'b1, flash_pkg::UNLOCK_A1, flash_pkg::UPPER_DONT_CARE, code};
    end else if (step == flash_pkg::STEP_ID_READ && op == flash_pkg::OP_IDLOCK) begin
      seq_word = {1'b0, BOOT_TOP ? flash_pkg::LOCK_STAT_HI : flash_pkg::LOCK_STAT_LO, 16'h0000};
    end else if (step == 3'h4 && op == flash_pkg::OP_IDLOCK) begin
      seq_word = {1'b1, a, flash_pkg::UPPER_DONT_CARE, flash_pkg::CMD_ID_EXIT};
    end else if (step == 3'h3 && op == flash_pkg::OP_PROG) begin
      seq_word = {1'b1, a, d};
    end else if (step == 3'h5) begin
      case (op)
        flash_pkg::OP_CHIP: seq_word = {1'b1, flash_pkg::UNLOCK_A1, flash_pkg::UPPER_DONT_CARE,
                                        flash_pkg::CMD_CHIP};
        flash_pkg::OP_SECT: seq_word = {1'b1, a, flash_pkg::UPPER_DONT_CARE, flash_pkg::CMD_SECT};
        default: seq_word = {1'b1, flash_pkg::UNLOCK_A1, flash_pkg::UPPER_DONT_CARE, flash_pkg::CMD_LOCK};
      endcase
    end
  endfunction : seq_word

  function automatic logic [2:0] seq_len(input logic [2:0] op);
    case (op)
      flash_pkg::OP_READ: seq_len = flash_pkg::LEN_READ;
      flash_pkg::OP_PROG: seq_len = flash_pkg::LEN_PROG;
      flash_pkg::OP_IDLOCK: seq_len = flash_pkg::LEN_IDLOCK;
      default: seq_len = flash_pkg::LEN_SIX;
    endcase
  endfunction : seq_len

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic in_boot;
  logic [35:0] step_word;
  logic toggle_stopped;
  logic poll_true;
  logic is_prog;

  assign in_boot = BOOT_TOP ? (cmd_addr_i >= flash_pkg::BOOT_HI_BASE)
                            : (cmd_addr_i <= flash_pkg::BOOT_LO_LAST);
  assign step_word = seq_word(cur_ff.op, cur_ff.step, cur_ff.addr, cur_ff.wdata);
  assign is_prog = (cur_ff.op == flash_pkg::OP_PROG);
  assign toggle_stopped = cur_ff.have_prev &&
                          (cur_ff.prev[flash_pkg::TOGGLE_BIT] == cyc_bus.rdata[flash_pkg::TOGGLE_BIT]);
  // Program: poll bit shows the complement until true data; erase: zero until all ones
  assign poll_true = is_prog ? (cyc_bus.rdata[flash_pkg::POLL_BIT] == cur_ff.wdata[flash_pkg::POLL_BIT])
                             : (cyc_bus.rdata == flash_pkg::ERASED_WORD);

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.done = 1'b0;
    nxt_cur.req = 1'b0;
    case (cur_ff.st)
      flash_pkg::S_IDLE: begin
        nxt_cur.busy = 1'b0;
        if (cmd_valid_i) begin
          nxt_cur.op = cmd_op_i;
          nxt_cur.addr = cmd_addr_i;
          nxt_cur.wdata = cmd_data_i;
          nxt_cur.step = 3'h0;
          nxt_cur.err = 1'b0;
          nxt_cur.have_prev = 1'b0;
          nxt_cur.tmo = (cmd_op_i == flash_pkg::OP_PROG) ? PROG_TMO : ERASE_TMO;
          if (cur_ff.locked && in_boot &&
              (cmd_op_i == flash_pkg::OP_PROG || cmd_op_i == flash_pkg::OP_SECT)) begin
            nxt_cur.err = 1'b1;
            nxt_cur.done = 1'b1;
          end else begin
            nxt_cur.busy = 1'b1;
            nxt_cur.st = flash_pkg::S_ISSUE;
          end
        end
      end
      flash_pkg::S_ISSUE: begin
        nxt_cur.req = 1'b1;
        nxt_cur.wr = step_word[35];
        nxt_cur.caddr = step_word[34:16];
        nxt_cur.cdata = step_word[15:0];
        nxt_cur.st = flash_pkg::S_WAIT;
      end
      flash_pkg::S_WAIT: begin
        if (cyc_bus.done) begin
          if (!cur_ff.wr) begin
            nxt_cur.rdata = cyc_bus.rdata;
          end
          if (cur_ff.op == flash_pkg::OP_IDLOCK && cur_ff.step == flash_pkg::STEP_ID_READ) begin
            nxt_cur.locked = cyc_bus.rdata[flash_pkg::LOCK_BIT];
          end
          if (cur_ff.step == seq_len(cur_ff.op) - 3'h1) begin
            // Lockout sets state with no internal operation, so no polling is needed
            if (cur_ff.op == flash_pkg::OP_PROG || cur_ff.op == flash_pkg::OP_CHIP ||
                cur_ff.op == flash_pkg::OP_SECT) begin
              nxt_cur.st = flash_pkg::S_POLL;
            end else begin
              if (cur_ff.op == flash_pkg::OP_LOCK) begin
                nxt_cur.locked = 1'b1;
              end
              nxt_cur.done = 1'b1;
              nxt_cur.st = flash_pkg::S_IDLE;
            end
          end else begin
            nxt_cur.step = cur_ff.step + 3'h1;
            nxt_cur.st = flash_pkg::S_ISSUE;
          end
        end
      end
      flash_pkg::S_POLL: begin
        nxt_cur.req = 1'b1;
        nxt_cur.wr = 1'b0;
        nxt_cur.caddr = cur_ff.addr; // Command address, the last loaded location except for chip erase
        nxt_cur.st = flash_pkg::S_PWAIT;
      end
      flash_pkg::S_PWAIT: begin
        if (cur_ff.tmo != 32'h0) begin
          nxt_cur.tmo = cur_ff.tmo - 32'h1;
        end
        if (cyc_bus.done) begin
          nxt_cur.prev = cyc_bus.rdata;
          nxt_cur.have_prev = 1'b1;
          nxt_cur.rdata = cyc_bus.rdata;
          if (toggle_stopped && poll_true) begin
            nxt_cur.done = 1'b1;
            nxt_cur.st = flash_pkg::S_IDLE;
          end else if (cur_ff.tmo == 32'h0) begin
            // Stuck operation: reset the flash rather than poll forever
            nxt_cur.err = 1'b1;
            nxt_cur.rst_n = 1'b0;
            nxt_cur.rcnt = flash_pkg::RST_LOW_CYC;
            nxt_cur.st = flash_pkg::S_RST;
          end else begin
            nxt_cur.st = flash_pkg::S_POLL;
          end
        end
      end
      flash_pkg::S_RST: begin
        if (cur_ff.rcnt > 8'h01) begin
          nxt_cur.rcnt = cur_ff.rcnt - 8'h01;
        end else begin
          nxt_cur.rst_n = 1'b1;
          nxt_cur.done = 1'b1;
          nxt_cur.st = flash_pkg::S_IDLE;
        end
      end
      default: begin
        nxt_cur.st = flash_pkg::S_IDLE;
      end
    endcase
    // Abort waits for the pin engine to finish so the strobe never glitches
    if (abort_i && cur_ff.st != flash_pkg::S_RST && cur_ff.st != flash_pkg::S_ISSUE &&
        cur_ff.st != flash_pkg::S_POLL && !(cur_ff.st == flash_pkg::S_WAIT && !cyc_bus.done) &&
        !(cur_ff.st == flash_pkg::S_PWAIT && !cyc_bus.done)) begin
      nxt_cur.rst_n = 1'b0;
      nxt_cur.rcnt = flash_pkg::RST_LOW_CYC;
      nxt_cur.busy = 1'b1;
      nxt_cur.done = 1'b0;
      nxt_cur.err = (cur_ff.st == flash_pkg::S_PWAIT);
      nxt_cur.st = flash_pkg::S_RST;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cur_ff <= '{st: flash_pkg::S_IDLE, op: 3'h0, addr: 19'h00000, wdata: 16'h0000, step: 3'h0,
                  prev: 16'h0000, have_prev: 1'b0, tmo: 32'h0, rcnt: 8'h00, busy: 1'b0, done: 1'b0,
                  err: 1'b0, rdata: 16'h0000, locked: 1'b0, rst_n: 1'b1, req: 1'b0, wr: 1'b0,
                  caddr: 19'h00000, cdata: 16'h0000};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ---------------------------------------------------------------
  // Pin engine
  // ---------------------------------------------------------------
  assign cyc_bus.req = cur_ff.req;
  assign cyc_bus.wr = cur_ff.wr;
  assign cyc_bus.addr = cur_ff.caddr;
  assign cyc_bus.wdata = cur_ff.cdata;

  flash_bus_cycle u_cycle (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .cyc(cyc_bus),
    .ce_n_o(ce_n_o),
    .oe_n_o(oe_n_o),
    .we_n_o(we_n_o),
    .addr_o(addr_o),
    .dq_o(dq_o),
    .dq_oe_o(dq_oe_o),
    .dq_i(dq_i)
  );

  assign busy_o = cur_ff.busy;
  assign done_o = cur_ff.done;
  assign err_o = cur_ff.err;
  assign rdata_o = cur_ff.rdata;
  assign locked_o = cur_ff.locked;
  assign flash_rst_n_o = cur_ff.rst_n;
endmodule : flash_host_ctrl

// >>> bench/flash_host_ctrl_properties.sv
// Pin checker for the flash host controller.
// Assumes it is bound to flash_host_ctrl.
`timescale 1ns/1ns
module flash_host_ctrl_properties (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic busy_o,
  input wire logic flash_rst_n_o,
  input wire logic ce_n_o,
  input wire logic oe_n_o,
  input wire logic we_n_o,
  input wire logic [18:0] addr_o,
  input wire logic [15:0] dq_o,
  input wire logic dq_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  sequence we_low_two;
    !we_n_o ##1 we_n_o;
  endsequence
  chk_read_strobes: assert property (!oe_n_o |-> !ce_n_o && we_n_o)
    else $error("read strobes wrong");
  chk_bus_free: assert property (!oe_n_o |-> !dq_oe_o)
    else $error("data contention");
  chk_reset_idle: assert property ($fell(sys_rst_i) |-> ce_n_o && we_n_o && !dq_oe_o && flash_rst_n_o)
    else $error("not idle after reset");
  chk_write_ctl: assert property (!we_n_o |-> oe_n_o && !ce_n_o && dq_oe_o)
    else $error("write strobes wrong");
  chk_we_pulse: assert property ($fell(we_n_o) |=> we_low_two)
    else $error("write pulse length");
  chk_write_hold: assert property (!we_n_o |=> $stable(addr_o) && $stable(dq_o))
    else $error("write data moved");
  chk_abort_len: assert property ($fell(flash_rst_n_o) |=> !flash_rst_n_o [*8])
    else $error("reset pulse short");
  chk_abort_quiet: assert property (!flash_rst_n_o |-> ce_n_o && we_n_o && !dq_oe_o)
    else $error("strobe during reset");
  chk_idle_standby: assert property (!busy_o |-> ce_n_o)
    else $error("selected while idle");
endmodule : flash_host_ctrl_properties
bind flash_host_ctrl flash_host_ctrl_properties i_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .busy_o(busy_o),
  .flash_rst_n_o(flash_rst_n_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o), .addr_o(addr_o),
  .dq_o(dq_o), .dq_oe_o(dq_oe_o));

// >>> bench/flash_model.sv
// Behavioural bottom boot flash.
// Assumes strobes from the host; times in ns.
`timescale 1ns/1ns
module flash_model #(
  parameter int PROG_NS = 1200,
  parameter int ERASE_NS = 2000
) (
  input wire logic rst_n_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [18:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o
);
  logic [15:0] mem [int];
  logic [15:0] q = 16'h0;
  logic [15:0] pd;
  logic [18:0] la, pa;
  logic busy = 0, ers = 0, tog = 0, locked = 0, id = 0;
  int step = 0, mode = 0, gen = 0;
  wire rd = !ce_n_i && !oe_n_i && we_n_i;
  function automatic logic [15:0] get(input int a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction : get
  task automatic erase(input int lo, input int hi);
    int k[$];
    foreach (mem[a]) if (a >= lo && a <= hi && !(locked && a < 'h2000)) k.push_back(a);
    foreach (k[i]) mem.delete(k[i]);
  endtask : erase
  task automatic start(input int k);
    int g;
    busy = 1;
    ers = k != 0;
    gen++;
    g = gen;
    fork begin
      #(ers ? ERASE_NS : PROG_NS);
      if (g == gen) begin
        if (k == 0) mem[pa] = get(pa) & pd;
        else if (k == 1) erase(0, 'h7ffff);
        else if (pa[18:12] == 7'h03) erase('h2000, 'h3fff);
        else if (pa[18:12] == 7'h05) erase('h4000, 'h5fff);
        else if (pa[18:12] == 7'h7f) begin
          erase(0, 'h1fff);
          erase('h6000, 'h7ffff);
        end
        busy = 0;
      end
    end join_none
  endtask : start
  task automatic cmd(input logic [18:0] a, input logic [7:0] c, input logic [15:0] d);
    int s = 0;
    if (id && c == 8'hf0) id = 0;
    else if (step == 3 && mode == 1) begin
      pa = a;
      pd = d;
      if (!(locked && a < 19'h02000)) start(0);
    end else if ((step == 0 || step == 3) && a == 19'h05555 && c == 8'haa) s = step + 1;
    else if ((step == 1 || step == 4) && a == 19'h02aaa && c == 8'h55) s = step + 1;
    else if (step == 2 && a == 19'h05555) begin
      s = (c == 8'ha0 || c == 8'h80) ? 3 : 0;
      mode = c == 8'ha0;
      id = c == 8'h90 ? 1'b1 : id;
    end else if (step == 5) begin
      pa = a;
      if (a == 19'h05555 && c == 8'h40) locked = 1;
      if (a == 19'h05555 && c == 8'h10) start(1);
      if (c == 8'h30) start(2);
    end
    step = s;
  endtask : cmd
  always @(negedge we_n_i) if (!ce_n_i) la = addr_i;
  always @(posedge we_n_i) if (!ce_n_i && oe_n_i && rst_n_i && !busy) cmd(la, dq_i[7:0], dq_i);
  always @(negedge rst_n_i) begin
    if (busy && !ers) mem[pa] = pd ^ 16'h00ff;
    busy = 0;
    step = 0;
    id = 0;
    gen++;
  end
  always @(posedge rd) begin
    tog = busy ? ~tog : tog;
    q = (id && addr_i == 19'h00002) ? {15'h0, locked} : get(addr_i);
    if (busy) q[7:6] = {ers ? 1'b0 : ~pd[7], tog};
  end
  // Released pins show the inverse so a stale value cannot pass
  assign dq_o = (rd && rst_n_i) ? q : ~q;
endmodule : flash_model

// >>> bench/parallel_flash_command_sequencer_tb.sv
// Bench for the flash host controller with a behavioural flash.
// Assumes bottom boot and shortened poll timeouts.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module parallel_flash_command_sequencer_tb;
  logic mclk_i = 0, sys_rst_i = 1, cmd_valid_i = 0, abort_i = 0, ref_lock = 0;
  logic [2:0] cmd_op_i = 3'h0;
  logic [18:0] cmd_addr_i = 19'h0;
  logic [15:0] cmd_data_i = 16'h0;
  logic busy_o, done_o, err_o, locked_o, frst_n, ce_n, oe_n, we_n, dq_oe;
  logic [15:0] rdata_o, dq_o, fdq;
  logic [18:0] addr_o;
  logic [15:0] ref_m [int];
  int fail_count = 0, checks = 0, cyc = 0;
  wire [15:0] bus = dq_oe ? dq_o : fdq;
  flash_host_ctrl #(.PROG_TMO(32'h32), .ERASE_TMO(32'hc8), .BOOT_TOP(1'b0)) i_dut (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
    .cmd_data_i(cmd_data_i), .abort_i(abort_i), .busy_o(busy_o), .done_o(done_o), .err_o(err_o),
    .rdata_o(rdata_o), .locked_o(locked_o), .flash_rst_n_o(frst_n), .ce_n_o(ce_n), .oe_n_o(oe_n),
    .we_n_o(we_n), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe), .dq_i(bus));
  flash_model i_flash (.rst_n_i(frst_n), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(addr_o),
    .dq_i(bus), .dq_o(fdq));
  initial forever #20 mclk_i = ~mclk_i;
  function automatic logic [15:0] rd_ref(input logic [18:0] a);
    return ref_m.exists(a) ? ref_m[a] : 16'hffff;
  endfunction : rd_ref
  task automatic ers_ref(input int lo, input int hi);
    foreach (ref_m[a]) if (a >= lo && a <= hi && !(ref_lock && a < 'h2000)) ref_m[a] = 16'hffff;
  endtask : ers_ref
  task automatic run(input logic [2:0] o, input logic [18:0] a, input logic [15:0] d, input logic e);
    int n = 0;
    @(posedge mclk_i) #2;
    cmd_valid_i = 1;
    cmd_op_i = o;
    cmd_addr_i = a;
    cmd_data_i = d;
    @(posedge mclk_i) #2;
    cmd_valid_i = 0;
    while (done_o !== 1'b1 && n < 4000) begin
      @(posedge mclk_i) #2;
      n++;
    end
    `CHK("done", 1'b1, done_o)
    `CHK("err", e, err_o)
  endtask : run
  task automatic rd_chk(input logic [18:0] a);
    run(3'h0, a, 16'h0, 1'b0);
    `CHK("rdata", rd_ref(a), rdata_o)
  endtask : rd_chk
  task automatic prog(input logic [18:0] a, input logic [15:0] d);
    run(3'h1, a, d, 1'b0);
    ref_m[a] = rd_ref(a) & d;
    rd_chk(a);
  endtask : prog
  task automatic complete_run;
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // Ceiling is far above the few thousand cycles the sequence needs
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 50000) begin
      fail_count++;
      complete_run;
    end
  end
  initial begin
    logic [18:0] a;
    logic [15:0] d;
    void'($urandom(7804));
    repeat (8) @(posedge mclk_i);
    #2 sys_rst_i = 0;
    `CHK("idle", 1'b0, busy_o | locked_o)
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 19'h00010 : 19'h06000 + 19'($urandom_range(0, 'h79fff));
      d = 16'($urandom);
      prog(a, d);
      prog(a, d & 16'($urandom) & 16'hff7f);
    end
    prog(19'h02000, 16'($urandom));
    run(3'h3, 19'h7f000, 16'h0, 1'b0);
    ers_ref(0, 'h1fff);
    ers_ref('h6000, 'h7ffff);
    foreach (ref_m[k]) rd_chk(k);
    prog(19'h00010, 16'h0a5a);
    prog(19'h04000, 16'h1234);
    run(3'h3, 19'h05000, 16'h0, 1'b0);
    ers_ref('h4000, 'h5fff);
    rd_chk(19'h04000);
    rd_chk(19'h02000);
    run(3'h5, 19'h00000, 16'h0, 1'b0);
    `CHK("lock", 1'b0, locked_o)
    run(3'h4, 19'h0, 16'h0, 1'b0);
    ref_lock = 1;
    `CHK("lock", 1'b1, locked_o)
    run(3'h5, 19'h0, 16'h0, 1'b0);
    `CHK("lockbit", 1'b1, rdata_o[0])
    run(3'h1, 19'h01fff, 16'h0, 1'b1);
    run(3'h3, 19'h00000, 16'h0, 1'b1);
    run(3'h2, 19'h7f000, 16'h0, 1'b0);
    ers_ref(0, 'h7ffff);
    foreach (ref_m[k]) rd_chk(k);
    fork
      run(3'h1, 19'h07000, 16'h0f0f, 1'b1);
      begin
        repeat (40) @(posedge mclk_i);
        #2 abort_i = 1;
        // Drop abort once taken, else the idle sequencer would reset the flash again
        while (frst_n !== 1'b0) @(posedge mclk_i) #2;
        abort_i = 0;
      end
    join
    rd_chk(19'h7f000);
    complete_run;
  end
endmodule : parallel_flash_command_sequencer_tb
